// >>> lpd_map.svh
// Constants of the pixel-link deserializer: bit counts, field positions,
// lock and stall figures, timing.
// Assumes it is included by its bare name wherever a figure is needed.
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH

// Lane geometry
`define LPD_BITS_PER_LANE 7
`define LPD_LANES_WIDE 4
`define LPD_LANES_NARROW 3

// Bit counter figures, four bits wide
`define LPD_FIRST_BIT 4'h0
`define LPD_LAST_BIT 4'h6
`define LPD_BIT_LIMIT 4'h7
`define LPD_RCLK_FALL_BIT 4'h4
`define LPD_STALL_BITS 4'he

// Consecutive good link periods before lock
`define LPD_LOCK_FRAMES 3'h4

// Lock deadline in its own unit, clock rate, and derived cycle count
`define LPD_LOCK_TIME_US 10000
`define LPD_CLOCK_KHZ 20000
`define LPD_LOCK_TIMEOUT_CYCLES ((`LPD_LOCK_TIME_US * `LPD_CLOCK_KHZ) / 1000)

// Control bit positions inside the wide word
`define LPD_SPARE_POS 23
`define LPD_HSYNC_POS 24
`define LPD_VSYNC_POS 25
`define LPD_VALID_POS 26

`endif

// >>> lpd_pkg.sv
// Types of the pixel-link deserializer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lpd_pkg;

    // Receiver operating states
    typedef enum logic [1:0] {
        ST_POWER_DOWN = 2'b00,
        ST_ACQUIRE = 2'b01,
        ST_LOCKED = 2'b10,
        ST_STALLED = 2'b11
    } lpd_state_t;

    // Position of a bit inside one lane period
    typedef logic [2:0] lpd_bit_index_t;

endpackage

`default_nettype wire

// >>> lpd_lane_if.sv
// Carrier between the deserializer core and one lane collector.
// Assumes one instance per data lane, all on the core clock.
`timescale 1ns/1ps
`default_nettype none

interface lpd_lane_if;
    logic sample; // Write the current bit this cycle
    lpd_pkg::lpd_bit_index_t bit_index; // Where the bit lands
    logic serial_bit; // Synchronised lane level
    logic [6:0] bits; // Collected bits of the period

    // Core side drives the strobe, reads the bits
    modport ctrl (output sample, output bit_index, output serial_bit, input bits);
    // Collector side
    modport lane (input sample, input bit_index, input serial_bit, output bits);
endinterface

`default_nettype wire

// >>> lpd_lane_deser.sv
// One lane collector: drops each serial bit into its slot of a 7-bit word.
// Assumes the core gives a synchronised bit and its slot every cycle.
`timescale 1ns/1ps
`default_nettype none

module lpd_lane_deser (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    lpd_lane_if.lane lane_io
);

    logic [6:0] bits; // Slots of the current period
    logic [6:0] next_bits;

    // Slot n takes serial bit n, fixed order every period
    always_comb begin
        next_bits = bits;
        if (lane_io.sample) begin
            next_bits[lane_io.bit_index] = lane_io.serial_bit; // R5 R15
        end
    end

    // Register only; frozen while the clock enable is low
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bits <= 7'h00;
        end else if (ce_in) begin
            bits <= next_bits;
        end
    end

    assign lane_io.bits = bits;

endmodule

`default_nettype wire

// >>> lpd_deserializer.sv
// Pixel-link receiver core: locks to the forwarded link clock lane and turns
// seven-bit lane periods into one parallel word per link period.
// Assumes CLOCK_IN runs at the serial bit rate, so that one link period is
// seven CLOCK_IN cycles, and that all link pins are asynchronous to it.
//
// Functional notes
// R1 - Wide variant: four lanes, 28-bit word
// R2 - Narrow variant: three lanes, 21-bit word
// R3 - Wide word: 24 colour, four control bits
// R4 - Lock internal timing to link clock lane
// R5 - Seven bits per lane per link period
// R6 - Deserialize only after lock achieved
// R7 - Outputs stable for falling recovered clock edge
// R8 - Power-down low forces low-power mode anytime
// R9 - Link clock lost: clocks stop, data holds
// R10 - Transmitter keeps link clock within range
// R11 - Dedicated clock lane is timing reference
// R12 - Power-down low drives outputs low
// R13 - Sample bit n mid-bit in period
// R14 - Lock acquired within ten milliseconds
// R15 - Bit n of lanes maps to output n
// R16 - Outputs invalid until lock after power-up
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.svh"

module lpd_deserializer #(
    parameter int LANES = `LPD_LANES_WIDE, // 4 wide, 3 narrow
    parameter int LOCK_TIMEOUT_CYCLES = `LPD_LOCK_TIMEOUT_CYCLES,
    localparam int WIDTH = `LPD_BITS_PER_LANE * LANES
) (
    input wire logic CLOCK_IN,
    input wire logic RSTN_IN,
    input wire logic CLK_EN_IN,
    input wire logic POWER_DOWN_N_IN,
    input wire logic LINK_CLOCK_IN,
    input wire logic [LANES-1:0] SERIAL_DATA_LANE_IN,
    output logic [WIDTH-1:0] PARALLEL_DATA_OUT,
    output logic RECOVERED_CLOCK_OUT,
    output logic LOCKED_OUT
);

    localparam int TIMER_W = $clog2(LOCK_TIMEOUT_CYCLES + 1);
    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(LOCK_TIMEOUT_CYCLES - 1);

    // Synchroniser stages; stage 1 feeds stage 2 only
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_s3; // Delayed copy for edge finding
    logic pd_s1;
    logic pd_s2;
    logic [LANES-1:0] data_s1;
    logic [LANES-1:0] data_s2;
    logic next_lclk_s1;
    logic next_lclk_s2;
    logic next_lclk_s3;
    logic next_pd_s1;
    logic next_pd_s2;
    logic [LANES-1:0] next_data_s1;
    logic [LANES-1:0] next_data_s2;

    // Control state
    lpd_pkg::lpd_state_t state;
    lpd_pkg::lpd_state_t next_state;
    logic [3:0] bit_cnt; // Bit slot of last cycle, saturates at stall
    logic [3:0] next_bit; // Bit slot of this cycle
    logic [2:0] good_cnt; // Consecutive seven-bit link periods
    logic [2:0] next_good_cnt;
    logic [TIMER_W-1:0] timer; // Time spent hunting for lock
    logic [TIMER_W-1:0] next_timer;
    logic rclk;
    logic next_rclk;
    logic locked;
    logic next_locked;
    logic [WIDTH-1:0] out_word;
    logic [WIDTH-1:0] next_out_word;

    // Derived each cycle
    logic link_edge; // Rising edge of the clock lane
    logic period_ok; // Edge landed exactly after slot six
    logic [WIDTH-1:0] lane_word; // Collected bits of all lanes

    // Synchroniser next values: data and clock lane share the same delay,
    // so the bit slots stay aligned to the clock lane edge
    always_comb begin
        next_lclk_s1 = LINK_CLOCK_IN;
        next_lclk_s2 = lclk_s1;
        next_lclk_s3 = lclk_s2;
        next_pd_s1 = POWER_DOWN_N_IN;
        next_pd_s2 = pd_s1;
        next_data_s1 = SERIAL_DATA_LANE_IN;
        next_data_s2 = data_s1;
    end

    // Synchroniser registers; power-down reads as asserted out of reset
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_s3 <= 1'b0;
            pd_s1 <= 1'b0;
            pd_s2 <= 1'b0;
            data_s1 <= '0;
            data_s2 <= '0;
        end else if (CLK_EN_IN) begin
            lclk_s1 <= next_lclk_s1;
            lclk_s2 <= next_lclk_s2;
            lclk_s3 <= next_lclk_s3;
            pd_s1 <= next_pd_s1;
            pd_s2 <= next_pd_s2;
            data_s1 <= next_data_s1;
            data_s2 <= next_data_s2;
        end
    end

    // The clock lane alone marks where a link period starts
    assign link_edge = lclk_s2 & ~lclk_s3; // R11
    assign period_ok = link_edge && (bit_cnt == `LPD_LAST_BIT); // R4 R5

    // Bit slot of this cycle: zero at each clock lane edge, then one per
    // cycle; sampling each slot at mid-bit relies on the sample clock being
    // centred in the bit, which the common synchroniser delay preserves
    always_comb begin
        if (link_edge) begin
            next_bit = `LPD_FIRST_BIT; // R13
        end else if (bit_cnt != `LPD_STALL_BITS) begin
            next_bit = bit_cnt + 4'h1; // R13
        end else begin
            next_bit = bit_cnt; // No edges: counter parks
        end
    end

    // One collector per lane; lane g fills outputs 7g to 7g+6
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        lpd_lane_if lane_bus ();

        // Only real slots are written, never the overrun ones
        assign lane_bus.sample = (next_bit < `LPD_BIT_LIMIT) && (state != lpd_pkg::ST_POWER_DOWN);
        assign lane_bus.bit_index = next_bit[2:0];
        assign lane_bus.serial_bit = data_s2[g];
        assign lane_word[g*`LPD_BITS_PER_LANE +: `LPD_BITS_PER_LANE] = lane_bus.bits; // R1 R2 R15

        lpd_lane_deser u_lane (
            .clk_in(CLOCK_IN),
            .rstn_in(RSTN_IN),
            .ce_in(CLK_EN_IN),
            .lane_io(lane_bus.lane)
        );
    end

    // Receiver next state. The word carries colour and the control bits
    // (sync, pixel_valid, spare_control_bit) at fixed slots; this core does
    // not interpret them, which keeps both variants on one datapath
    always_comb begin
        next_state = state;
        next_good_cnt = good_cnt;
        next_timer = timer;
        next_rclk = rclk;
        next_locked = locked;
        next_out_word = out_word; // R3
        case (state)
            lpd_pkg::ST_POWER_DOWN: begin
                // Leave only once the pin is released
                next_good_cnt = 3'h0;
                next_timer = '0;
                if (pd_s2) begin
                    next_state = lpd_pkg::ST_ACQUIRE;
                end
            end
            lpd_pkg::ST_ACQUIRE: begin
                // Count good periods; restart the hunt at the deadline
                next_locked = 1'b0; // R16
                next_rclk = 1'b0; // No recovered clock while hunting
                if (timer == TIMER_LAST) begin
                    next_timer = '0; // R14
                    next_good_cnt = 3'h0; // R14
                end else begin
                    next_timer = timer + TIMER_W'(1);
                end
                if (period_ok) begin
                    if (good_cnt == `LPD_LOCK_FRAMES - 3'h1) begin
                        next_state = lpd_pkg::ST_LOCKED; // R4 R14
                        next_locked = 1'b1; // R16
                        next_good_cnt = 3'h0;
                    end else begin
                        next_good_cnt = good_cnt + 3'h1;
                    end
                end else if (link_edge) begin
                    next_good_cnt = 3'h0; // Wrong period length
                end
            end
            lpd_pkg::ST_LOCKED: begin
                // Rises with each new word, falls four slots later, so the
                // word is steady at the falling edge; the period that ends
                // at the lock edge brings no word, so it brings no pulse
                if (next_bit == `LPD_FIRST_BIT) begin
                    next_rclk = 1'b1; // R7
                end else if (next_bit == `LPD_RCLK_FALL_BIT) begin
                    next_rclk = 1'b0; // R7
                end
                if (period_ok) begin
                    next_out_word = lane_word; // R6 R7
                end else if (link_edge) begin
                    // Broken period: keep the last word, hunt again
                    next_state = lpd_pkg::ST_ACQUIRE;
                    next_locked = 1'b0;
                    next_rclk = 1'b0; // No pulse for a word not taken
                end else if (next_bit == `LPD_STALL_BITS) begin
                    next_state = lpd_pkg::ST_STALLED; // R9
                end
            end
            lpd_pkg::ST_STALLED: begin
                // Clock lane gone: recovered clock and data freeze
                if (link_edge) begin
                    next_state = lpd_pkg::ST_ACQUIRE; // R9
                    next_locked = 1'b0;
                end
            end
            default: begin
                next_state = lpd_pkg::ST_POWER_DOWN;
            end
        endcase
        // Power-down overrides everything, whatever the link does
        if (!pd_s2) begin
            next_state = lpd_pkg::ST_POWER_DOWN; // R8
            next_rclk = 1'b0; // R8
            next_locked = 1'b0; // R16
            next_out_word = '0; // R12
        end
    end

    // Receiver registers; the bit counter sits here too
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state <= lpd_pkg::ST_POWER_DOWN;
            bit_cnt <= `LPD_STALL_BITS;
            good_cnt <= 3'h0;
            timer <= '0;
            rclk <= 1'b0;
            locked <= 1'b0;
            out_word <= '0;
        end else if (CLK_EN_IN) begin
            state <= next_state;
            bit_cnt <= next_bit;
            good_cnt <= next_good_cnt;
            timer <= next_timer;
            rclk <= next_rclk;
            locked <= next_locked;
            out_word <= next_out_word;
        end
    end

    // Outputs straight from registers
    assign PARALLEL_DATA_OUT = out_word;
    assign RECOVERED_CLOCK_OUT = rclk;
    assign LOCKED_OUT = locked;

endmodule

`default_nettype wire

// >>> lpd_deserializer_monitor.sv
// Port checker for the pixel-link deserializer core.
// Assumes it is bound to every core instance, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lpd_deserializer_monitor #(
    parameter int LANES = 4,
    parameter int LOCK_TIMEOUT_CYCLES = 64
) (
    input wire logic CLOCK_IN,
    input wire logic RSTN_IN,
    input wire logic CLK_EN_IN,
    input wire logic POWER_DOWN_N_IN,
    input wire logic LINK_CLOCK_IN,
    input wire logic [LANES-1:0] SERIAL_DATA_LANE_IN,
    input wire logic [7*LANES-1:0] PARALLEL_DATA_OUT,
    input wire logic RECOVERED_CLOCK_OUT,
    input wire logic LOCKED_OUT
);
    logic [3:0] rises; // Link rises since power-down, saturating
    logic [5:0] idle; // Cycles the link clock stood low
    logic link_d; // Link clock at the previous edge
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RSTN_IN || !CLK_EN_IN);
    // Helper counts; rises lost in power-down must not count toward lock
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rises <= 4'h0;
            idle <= 6'h00;
            link_d <= 1'b0;
        end else begin
            link_d <= LINK_CLOCK_IN;
            rises <= !POWER_DOWN_N_IN ? 4'h0 : rises + 4'(LINK_CLOCK_IN && !link_d && rises != 4'hf);
            idle <= LINK_CLOCK_IN ? 6'h00 : idle + 6'(idle != 6'h3f);
        end
    end
    sequence s_pd_held;
        !POWER_DOWN_N_IN [*3];
    endsequence
    sequence s_rclk_high;
        RECOVERED_CLOCK_OUT [*4] ##1 !RECOVERED_CLOCK_OUT;
    endsequence
    a_pd_zero: assert property (s_pd_held |=> PARALLEL_DATA_OUT == '0 && !LOCKED_OUT
        && !RECOVERED_CLOCK_OUT) else $error("outputs not cleared in power-down");
    a_rclk_high: assert property (disable iff (!RSTN_IN || !CLK_EN_IN || !POWER_DOWN_N_IN)
        $rose(RECOVERED_CLOCK_OUT) |-> s_rclk_high) else $error("recovered clock high time");
    a_rclk_low: assert property ($fell(RECOVERED_CLOCK_OUT) |-> !RECOVERED_CLOCK_OUT [*3])
        else $error("recovered clock low time");
    a_word_on_rise: assert property (!$stable(PARALLEL_DATA_OUT) |->
        $rose(RECOVERED_CLOCK_OUT) || PARALLEL_DATA_OUT == '0) else $error("word off clock");
    a_no_early_data: assert property (!$past(LOCKED_OUT) |->
        $stable(PARALLEL_DATA_OUT) || PARALLEL_DATA_OUT == '0) else $error("word before lock");
    a_rclk_locked: assert property ($rose(RECOVERED_CLOCK_OUT) |->
        LOCKED_OUT && $past(LOCKED_OUT)) else $error("recovered clock while unlocked");
    a_lock_rises: assert property ($rose(LOCKED_OUT) |-> rises >= 4'h4)
        else $error("lock without link periods");
    a_stall_hold: assert property (idle > 6'h14 && POWER_DOWN_N_IN |->
        $stable(PARALLEL_DATA_OUT) && $stable(LOCKED_OUT) && $stable(RECOVERED_CLOCK_OUT))
        else $error("outputs moved with link stopped");
endmodule
bind lpd_deserializer lpd_deserializer_monitor #(
    .LANES(LANES),
    .LOCK_TIMEOUT_CYCLES(LOCK_TIMEOUT_CYCLES)
) u_lpd_deserializer_monitor (
    .CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .CLK_EN_IN(CLK_EN_IN),
    .POWER_DOWN_N_IN(POWER_DOWN_N_IN), .LINK_CLOCK_IN(LINK_CLOCK_IN),
    .SERIAL_DATA_LANE_IN(SERIAL_DATA_LANE_IN), .PARALLEL_DATA_OUT(PARALLEL_DATA_OUT),
    .RECOVERED_CLOCK_OUT(RECOVERED_CLOCK_OUT), .LOCKED_OUT(LOCKED_OUT)
);
`default_nettype wire

// >>> lpd_link_tx_model.sv
// Link transmitter model: forwarded clock plus seven bits a lane a period.
// Assumes the core clock paces it, one bit per cycle.
`timescale 1ns/1ps
`default_nettype none
module lpd_link_tx_model (
    input wire logic clk_in,
    input wire logic run_in,
    input wire logic [3:0] period_in,
    input wire logic [27:0] word_in,
    output logic link_clock_out,
    output logic [3:0] lane_out
);
    logic [3:0] slot = 4'h0; // Bit slot of the period
    logic [27:0] held = 28'h0000000; // Word of the running period
    logic [27:0] cur; // Word used in this slot
    initial link_clock_out = 1'b0;
    initial lane_out = 4'h0;
    // Word is taken whole at slot 0 so no period mixes two words
    assign cur = (slot == 4'h0) ? word_in : held;
    // Bit 0 leaves with the clock rise, then bits 1..6
    always @(posedge clk_in) begin
        if (!run_in) begin
            slot <= 4'h0;
            link_clock_out <= 1'b0;
            lane_out <= ~lane_out; // Stopped lanes toggle, never hold
        end else begin
            slot <= (slot + 4'h1 >= period_in) ? 4'h0 : slot + 4'h1;
            link_clock_out <= (slot < 4'h4);
            held <= cur;
            for (int g = 0; g < 4; g++) begin
                lane_out[g] <= cur[7 * g + slot];
            end
        end
    end
endmodule
`default_nettype wire

// >>> lpd_deserializer_tb.sv
// Testbench for the pixel-link deserializer, wide and narrow cores.
// Assumes the transmitter model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lpd_deserializer_tb;
    localparam logic [27:0] W_A = 28'h5a3c96e; // Control slots 23..26 mixed
    localparam logic [27:0] W_B = 28'ha5c3691;
    logic clock = 1'b0; // 20 MHz core clock
    logic rst_n = 1'b0;
    logic pd_n = 1'b1; // Power-down pin, low active
    logic ce = 1'b1; // Clock enable of both cores
    logic rclk_n; // Recovered clock of the narrow core
    logic lock_n; // Lock flag of the narrow core
    logic run = 1'b0; // Link running
    logic [3:0] period = 4'h7; // Cycles per link period
    logic [27:0] word = 28'h0000000;
    logic link_clk;
    logic [3:0] lanes;
    logic [27:0] wide;
    logic [20:0] narrow;
    logic rclk_w;
    logic lock_w;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #25 clock = ~clock;
    lpd_link_tx_model u_lpd_link_tx_model (
        .clk_in(clock), .run_in(run), .period_in(period), .word_in(word),
        .link_clock_out(link_clk), .lane_out(lanes)
    );
    lpd_deserializer #(.LANES(4), .LOCK_TIMEOUT_CYCLES(200)) u_lpd_deserializer (
        .CLOCK_IN(clock), .RSTN_IN(rst_n), .CLK_EN_IN(ce), .POWER_DOWN_N_IN(pd_n),
        .LINK_CLOCK_IN(link_clk), .SERIAL_DATA_LANE_IN(lanes), .PARALLEL_DATA_OUT(wide),
        .RECOVERED_CLOCK_OUT(rclk_w), .LOCKED_OUT(lock_w)
    );
    lpd_deserializer #(.LANES(3), .LOCK_TIMEOUT_CYCLES(200)) u_lpd_deserializer_narrow (
        .CLOCK_IN(clock), .RSTN_IN(rst_n), .CLK_EN_IN(ce), .POWER_DOWN_N_IN(pd_n),
        .LINK_CLOCK_IN(link_clk), .SERIAL_DATA_LANE_IN(lanes[2:0]),
        .PARALLEL_DATA_OUT(narrow), .RECOVERED_CLOCK_OUT(rclk_n), .LOCKED_OUT(lock_n)
    );
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic check_word(input logic [27:0] got, input logic [27:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected word at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected flag at %0t: %b not %b", $time, got, exp);
        end
    endtask
    // Sample a settled cycle, after the edge's updates land
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_lock(input logic lvl);
        for (int n = 0; n < 200 && lock_w !== lvl; n++) tick(1);
    endtask
    task automatic wait_rises(input int k);
        repeat (k) begin
            for (int n = 0; n < 20 && rclk_w !== 1'b0; n++) tick(1);
            for (int n = 0; n < 20 && rclk_w !== 1'b1; n++) tick(1);
        end
    endtask
    task automatic t_lock();
        word <= W_A;
        run <= 1'b1;
        tick(12);
        check_bit(lock_w, 1'b0);
        check_word(wide, 28'h0000000);
        wait_lock(1'b1);
        check_bit(lock_w, 1'b1);
        check_bit(lock_n, 1'b1);
        wait_rises(3);
        check_word(wide, W_A);
        check_word({7'h00, narrow}, {7'h00, W_A[20:0]});
        word <= W_B;
        wait_rises(3);
        check_word(wide, W_B);
        tick(3);
        check_bit(rclk_w, 1'b1);
        tick(1);
        check_bit(rclk_w, 1'b0);
    endtask
    // Freeze two whole link periods: outputs hold, phase and lock survive
    task automatic t_freeze();
        ce <= 1'b0;
        repeat (14) begin
            tick(1);
            check_bit(rclk_w, 1'b0);
        end
        check_bit(lock_w, 1'b1);
        check_word(wide, W_B);
        ce <= 1'b1;
        wait_rises(2);
        check_bit(lock_w, 1'b1);
        check_word(wide, W_B);
    endtask
    task automatic t_bad();
        period <= 4'h6;
        tick(7);
        period <= 4'h7;
        wait_lock(1'b0);
        check_bit(lock_w, 1'b0);
        check_word(wide, W_B);
        wait_lock(1'b1);
        check_bit(lock_w, 1'b1);
    endtask
    task automatic t_stall();
        run <= 1'b0;
        tick(40);
        check_word(wide, W_B);
        check_bit(rclk_w, 1'b0);
        check_word({7'h00, narrow}, {7'h00, W_B[20:0]});
        run <= 1'b1;
        wait_lock(1'b0);
        wait_lock(1'b1);
        check_bit(lock_w, 1'b1);
    endtask
    task automatic t_pd();
        pd_n <= 1'b0;
        tick(4);
        check_word(wide, 28'h0000000);
        check_bit(lock_w, 1'b0);
        tick(20);
        check_word({7'h00, narrow}, 28'h0000000);
        check_bit(rclk_w, 1'b0);
        check_bit(rclk_n, 1'b0);
        check_bit(lock_n, 1'b0);
        pd_n <= 1'b1;
        word <= W_A;
        wait_lock(1'b1);
        check_bit(lock_w, 1'b1);
        wait_rises(3);
        check_word(wide, W_A);
    endtask
    initial begin
        tick(3);
        rst_n <= 1'b1;
        t_lock();
        t_freeze();
        t_bad();
        t_stall();
        t_pd();
        test_done();
    end
endmodule
`default_nettype wire
